// ---- rtl/multi_speed_accel_select.sv ----
// Multi-speed frequency selector and first/second ramp-set switch with Avalon-MM registers.
// Assumes terminal pins asynchronous, analog value and ramp state on ref_clk_i.
`timescale 1ns/1ps
// Behaviour
// - Mode 00 binary eight, 01 bit four
// - Binary: three terminals form speed index
// - Binary speeds 1-7 use presets 1-7
// - Speed 0: operator value or analog input
// - Binary select accepted after settle delay
// - Bit: three terminals pick speeds 1-3
// - Bit speeds use presets 1-3
// - Lowest function number wins in bit mode
// - Ramp set may change mid-ramp
// - Switch method: terminal, threshold, reversal
// - Terminal switch only on function 09
// - Threshold switching, accel and decel separately
module multi_speed_accel_select
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [4:0] terminal_i,
  input wire logic [speed_sel_pkg::freq_w-1:0] analog_frequency_input_i,
  input wire logic [speed_sel_pkg::freq_w-1:0] output_frequency_i,
  input wire logic accelerating_i,
  input wire logic decelerating_i,
  input wire logic reversing_i,
  output logic [speed_sel_pkg::freq_w-1:0] output_frequency_setting_o,
  output logic [2:0] speed_index_o,
  output logic second_ramp_set_o
);
  import speed_sel_pkg::*;

  logic rst_m, rst_n;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  logic [4:0] term;
  input_sync u_sync
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .pins_i(terminal_i),
    .pins_o(term)
  );

  // Registers
  logic [31:0] ctrl, next_ctrl;
  logic [7:0] settle, next_settle;
  logic [15:0] speed0_operator_frequency, next_speed0;
  logic [15:0] accel_switch_threshold, next_accel_thr;
  logic [15:0] decel_switch_threshold, next_decel_thr;
  logic [5:0] term_fn [0:4];
  logic [5:0] next_term_fn [0:4];
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic tbl_we;
  logic [15:0] tbl_rdata;
  logic [1:0] preset_speed_mode_setting;
  logic [1:0] ramp_switch_method;
  logic freq_src_terminal;

  assign preset_speed_mode_setting = ctrl[ctrl_mode_lsb +: 2];
  assign ramp_switch_method = ctrl[ctrl_ramp_lsb +: 2];
  assign freq_src_terminal = ctrl[ctrl_src_bit];

  logic acc;
  assign acc = (avs_read || avs_write) && !ack;
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign avs_readdata = rdata;
  assign tbl_we = acc && avs_write && avs_address >= addr_preset1
    && avs_address < addr_accel_thr;

  logic [15:0] wr_clip;
  logic [2:0] cur_index;
  logic second_set;

  always_comb
  begin
    next_ctrl = ctrl;
    next_settle = settle;
    next_speed0 = speed0_operator_frequency;
    next_accel_thr = accel_switch_threshold;
    next_decel_thr = decel_switch_threshold;
    for (int i = 0; i < 5; i++)
      next_term_fn[i] = term_fn[i];
    next_rdata = rdata;
    next_ack = acc;
    wr_clip = (avs_writedata[15:0] > thresh_max) ? thresh_max : avs_writedata[15:0];
    if (acc && avs_write)
    begin
      case (avs_address)
        addr_ctrl: next_ctrl = {27'h0, avs_writedata[4:0]};
        addr_settle: next_settle = avs_writedata[7:0];
        addr_speed0: next_speed0 = avs_writedata[15:0];
        addr_accel_thr: next_accel_thr = wr_clip;
        addr_decel_thr: next_decel_thr = wr_clip;
        default:
        begin
          for (int i = 0; i < 5; i++)
            if (avs_address == addr_term_fn0 + 6'(i))
              next_term_fn[i] = avs_writedata[5:0];
        end
      endcase
    end
    if (acc && avs_read)
    begin
      case (avs_address)
        addr_ctrl: next_rdata = ctrl;
        addr_settle: next_rdata = {24'h0, settle};
        addr_speed0: next_rdata = {16'h0, speed0_operator_frequency};
        addr_accel_thr: next_rdata = {16'h0, accel_switch_threshold};
        addr_decel_thr: next_rdata = {16'h0, decel_switch_threshold};
        addr_status: next_rdata = {27'h0, second_set, 1'b0, cur_index};
        default:
        begin
          next_rdata = 32'h0000_0000;
          for (int i = 0; i < 5; i++)
            if (avs_address == addr_term_fn0 + 6'(i))
              next_rdata = {26'h0, term_fn[i]};
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= ctrl_reset;
      settle <= settle_reset;
      speed0_operator_frequency <= freq_reset;
      accel_switch_threshold <= freq_reset;
      decel_switch_threshold <= freq_reset;
      for (int i = 0; i < 5; i++)
        term_fn[i] <= 6'h00;
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      settle <= next_settle;
      speed0_operator_frequency <= next_speed0;
      accel_switch_threshold <= next_accel_thr;
      decel_switch_threshold <= next_decel_thr;
      for (int i = 0; i < 5; i++)
        term_fn[i] <= next_term_fn[i];
      rdata <= next_rdata;
      ack <= next_ack;
    end
  end

  // Map terminals to functions
  logic [2:0] binary_raw;
  logic [2:0] bit_sel;
  logic ramp_set_switch_input;
  logic binary_speed_sel_bit0, binary_speed_sel_bit1, binary_speed_sel_bit2;
  logic bit_speed_sel_1, bit_speed_sel_2, bit_speed_sel_3;
  always_comb
  begin
    binary_raw = 3'h0;
    bit_sel = 3'h0;
    ramp_set_switch_input = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (term_fn[i] == fn_binary_sel0 + 6'(b))
          binary_raw[b] = binary_raw[b] | term[i];
        if (term_fn[i] == fn_bit_sel1 + 6'(b))
          bit_sel[b] = bit_sel[b] | term[i];
      end
      if (term_fn[i] == fn_ramp_switch)
        ramp_set_switch_input = ramp_set_switch_input | term[i];
    end
  end
  assign binary_speed_sel_bit0 = binary_raw[0];
  assign binary_speed_sel_bit1 = binary_raw[1];
  assign binary_speed_sel_bit2 = binary_raw[2];
  assign bit_speed_sel_1 = bit_sel[0];
  assign bit_speed_sel_2 = bit_sel[1];
  assign bit_speed_sel_3 = bit_sel[2];

  // Settle timer for binary select
  logic [2:0] binary_last, next_binary_last, binary_taken, next_binary_taken;
  logic [26:0] unit_cnt, next_unit_cnt;
  logic [7:0] unit_num, next_unit_num;
  always_comb
  begin
    next_binary_last = {binary_speed_sel_bit2, binary_speed_sel_bit1, binary_speed_sel_bit0};
    next_binary_taken = binary_taken;
    next_unit_cnt = unit_cnt;
    next_unit_num = unit_num;
    if (next_binary_last != binary_last)
    begin
      next_unit_cnt = 27'h0;
      next_unit_num = 8'h00;
    end
    else if (unit_num >= settle)
      next_binary_taken = binary_last;
    else if (unit_cnt == 27'(settle_unit_cycles - 1))
    begin
      next_unit_cnt = 27'h0;
      next_unit_num = unit_num + 8'h01;
    end
    else
      next_unit_cnt = unit_cnt + 27'h1;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      binary_last <= 3'h0;
      binary_taken <= 3'h0;
      unit_cnt <= 27'h0;
      unit_num <= 8'h00;
    end
    else
    begin
      binary_last <= next_binary_last;
      binary_taken <= next_binary_taken;
      unit_cnt <= next_unit_cnt;
      unit_num <= next_unit_num;
    end
  end

  // Speed index and ramp-set choice
  always_comb
  begin
    if (preset_speed_mode_setting == mode_bit)
    begin
      if (bit_speed_sel_1)
        cur_index = 3'h1;
      else if (bit_speed_sel_2)
        cur_index = 3'h2;
      else if (bit_speed_sel_3)
        cur_index = 3'h3;
      else
        cur_index = 3'h0;
    end
    else
      cur_index = binary_taken;
    case (ramp_switch_method)
      ramp_by_terminal: second_set = ramp_set_switch_input;
      ramp_by_threshold: second_set =
        (accelerating_i && output_frequency_i >= accel_switch_threshold) ||
        (decelerating_i && output_frequency_i >= decel_switch_threshold);
      ramp_on_reverse: second_set = reversing_i;
      default: second_set = 1'b0;
    endcase
  end

  preset_table u_table
  (
    .ref_clk_i(ref_clk_i),
    .we_i(tbl_we),
    .waddr_i(3'(avs_address - addr_preset1 + 6'h01)),
    .wdata_i(avs_writedata[15:0]),
    .raddr_i(cur_index),
    .rdata_o(tbl_rdata)
  );

  logic [2:0] index_q;
  logic [15:0] freq_q, next_freq;
  logic second_q;
  always_comb
  begin
    if (index_q == 3'h0)
      next_freq = freq_src_terminal ? analog_frequency_input_i
        : speed0_operator_frequency;
    else
      next_freq = tbl_rdata;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      index_q <= 3'h0;
      freq_q <= freq_reset;
      second_q <= 1'b0;
    end
    else
    begin
      index_q <= cur_index;
      freq_q <= next_freq;
      second_q <= second_set;
    end
  end
  assign output_frequency_setting_o = freq_q;
  assign speed_index_o = index_q;
  assign second_ramp_set_o = second_q;
endmodule // multi_speed_accel_select

// ---- rtl/speed_sel_pkg.sv ----
// Package: constants, modes and register map for the multi-speed and ramp-set selector.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package speed_sel_pkg;
  localparam int freq_w = 16;
  localparam int clk_mhz = 100;
  localparam int settle_unit_ms = 10;
  localparam int settle_unit_cycles = settle_unit_ms * 1000 * clk_mhz;
  localparam logic [1:0] mode_binary = 2'h0;
  localparam logic [1:0] mode_bit = 2'h1;
  localparam logic [1:0] ramp_by_terminal = 2'h0;
  localparam logic [1:0] ramp_by_threshold = 2'h1;
  localparam logic [1:0] ramp_on_reverse = 2'h2;
  localparam logic [5:0] fn_binary_sel0 = 6'h02;
  localparam logic [5:0] fn_ramp_switch = 6'h09;
  localparam logic [5:0] fn_bit_sel1 = 6'h20;
  localparam logic [15:0] thresh_max = 16'h9C40;
  localparam logic [5:0] addr_ctrl = 6'h00;
  localparam logic [5:0] addr_settle = 6'h01;
  localparam logic [5:0] addr_speed0 = 6'h02;
  localparam logic [5:0] addr_preset1 = 6'h03;
  localparam logic [5:0] addr_accel_thr = 6'h0A;
  localparam logic [5:0] addr_decel_thr = 6'h0B;
  localparam logic [5:0] addr_term_fn0 = 6'h0C;
  localparam logic [5:0] addr_status = 6'h11;
  localparam int ctrl_mode_lsb = 0;
  localparam int ctrl_ramp_lsb = 2;
  localparam int ctrl_src_bit = 4;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [7:0] settle_reset = 8'h00;
  localparam logic [freq_w-1:0] freq_reset = 16'h0000;
endpackage

// ---- rtl/input_sync.sv ----
// Three-stage synchroniser for the terminal pins; a change counts once stages 2 and 3 agree.
// Assumes pins are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module input_sync
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] pins_i,
  output logic [4:0] pins_o
);
  logic [4:0] s1, s2, s3, held;
  logic [4:0] next_held;
  always_comb
  begin
    next_held = held;
    for (int i = 0; i < 5; i++)
      if (s2[i] == s3[i])
        next_held[i] = s3[i];
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
      held <= 5'h00;
    end
    else
    begin
      s1 <= pins_i;
      s2 <= s1;
      s3 <= s2;
      held <= next_held;
    end
  end
  assign pins_o = held;
endmodule // input_sync

// ---- rtl/preset_table.sv ----
// Eight-entry frequency memory: presets 1 to 7 plus unused entry 0, registered read port.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
module preset_table
(
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [2:0] raddr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:7];
  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
    rdata_o <= mem[raddr_i];
  end
endmodule // preset_table

// ---- bench/term_driver.sv ----
// Partner: external controller setting terminal pins and the motor ramp state.
// Assumes bench commands, applied at the next rising edge.
`timescale 1ns/1ps
module term_driver
(
  input wire logic ref_clk_i,
  input wire logic [4:0] pins_cmd_i,
  input wire logic [2:0] ramp_cmd_i,
  output logic [4:0] terminal_o,
  output logic [2:0] ramp_o
);
  // Pins change only after an edge, never on it
  always @(posedge ref_clk_i)
  begin
    terminal_o <= pins_cmd_i;
    ramp_o <= ramp_cmd_i;
  end
endmodule // term_driver

// ---- bench/multi_speed_accel_select_asserts.sv ----
// Checker: bus handshake, read-back and ramp-set stability.
// Assumes binding to the selector top module.
`timescale 1ns/1ps
module multi_speed_accel_select_asserts
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [4:0] terminal_i,
  input wire logic [speed_sel_pkg::freq_w-1:0] output_frequency_i,
  input wire logic accelerating_i,
  input wire logic decelerating_i,
  input wire logic reversing_i,
  input wire logic [2:0] speed_index_o,
  input wire logic second_ramp_set_o
);
  import speed_sel_pkg::*;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  logic [23:0] prev;
  logic [23:0] next_prev;
  // Cycles since any ramp-set cause last moved
  always_comb
  begin
    next_prev = {terminal_i, output_frequency_i, accelerating_i, decelerating_i, reversing_i};
    next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
    if (avs_write || next_prev != prev)
    begin
      next_quiet = 4'h0;
    end
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      quiet <= 4'h0;
      prev <= 24'h0;
    end
    else
    begin
      quiet <= next_quiet;
      prev <= next_prev;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low on first request cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  a_read_stands: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > addr_status
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_preset_zero: assert property (avs_read && !avs_waitrequest && avs_address >= addr_preset1
    && avs_address < addr_accel_thr |-> avs_readdata == 32'h0) else $error("preset readable");
  a_status_index: assert property (avs_read && !avs_waitrequest && avs_address == addr_status
    && $stable(speed_index_o) |-> avs_readdata[2:0] == speed_index_o)
    else $error("status index differs from output");
  a_status_ramp: assert property (avs_read && !avs_waitrequest && avs_address == addr_status
    && $stable(second_ramp_set_o) |-> avs_readdata[4] == second_ramp_set_o)
    else $error("status ramp set differs from output");
  a_ramp_quiet: assert property (quiet == 4'hF |-> $stable(second_ramp_set_o))
    else $error("ramp set changed with no cause");
endmodule // multi_speed_accel_select_asserts
bind multi_speed_accel_select multi_speed_accel_select_asserts chk (.ref_clk_i, .nrst_i,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .terminal_i,
  .output_frequency_i, .accelerating_i, .decelerating_i, .reversing_i, .speed_index_o,
  .second_ramp_set_o);

// ---- bench/multi_speed_accel_select_test.sv ----
// Testbench: registers over Avalon-MM, pins through term_driver, outputs checked.
// Assumes the bound checker; a long settle delay is only checked as not yet expired.
`timescale 1ns/1ps
module multi_speed_accel_select_test;
  import speed_sel_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] terminal_i;
  logic [4:0] pins = 5'h00;
  logic [2:0] ramp = 3'h0;
  logic [2:0] mot;
  logic [freq_w-1:0] analog_frequency_input_i = 16'h0000;
  logic [freq_w-1:0] output_frequency_i = 16'h0000;
  logic [freq_w-1:0] output_frequency_setting_o;
  logic [2:0] speed_index_o;
  logic second_ramp_set_o;
  logic [31:0] rd;
  int n_mismatch = 0;
  int n_tests = 0;
  multi_speed_accel_select dut (.ref_clk_i, .nrst_i, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .terminal_i, .analog_frequency_input_i,
    .output_frequency_i, .accelerating_i(mot[2]), .decelerating_i(mot[1]),
    .reversing_i(mot[0]), .output_frequency_setting_o, .speed_index_o, .second_ramp_set_o);
  term_driver drv (.ref_clk_i, .pins_cmd_i(pins), .ramp_cmd_i(ramp), .terminal_o(terminal_i),
    .ramp_o(mot));
  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task final_report;
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    if (n >= 20) final_report;
  endtask
  function automatic logic [15:0] pf(input logic [2:0] k);
    return (k == 3'h0) ? 16'h0111 : 16'h1000 + {13'h0, k} * 16'h0101;
  endfunction
  // Bounded wait for the expected selection, then compare
  task wt(input logic [2:0] ix, input logic [15:0] fq, input logic sr);
    int n;
    n = 0;
    // Let pin and register changes reach the outputs before judging
    repeat (12) @(posedge ref_clk_i);
    while ({speed_index_o, output_frequency_setting_o, second_ramp_set_o} !== {ix, fq, sr}
      && n < 200)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("speed index", ix, speed_index_o);
    chk("frequency", fq, output_frequency_setting_o);
    chk("second set", sr, second_ramp_set_o);
    if (n >= 200) final_report;
  endtask
  task set_fn(input logic [5:0] base);
    int i;
    for (i = 0; i < 3; i++) bus(1'b1, addr_term_fn0 + 6'(i), base + 6'(i));
  endtask
  task t_reset;
    wt(3'h0, 16'h0000, 1'b0);
    bus(1'b0, addr_ctrl, 32'h0);
    chk("ctrl reset", ctrl_reset, rd);
    bus(1'b0, addr_settle, 32'h0);
    chk("settle reset", {24'h0, settle_reset}, rd);
    bus(1'b1, 6'h3F, 32'hFFFF_FFFF);
    bus(1'b0, 6'h3F, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("reset test done");
  endtask
  task t_binary;
    int i;
    bus(1'b1, addr_settle, 32'h0);
    bus(1'b1, addr_speed0, 32'h0111);
    for (i = 1; i < 8; i++) bus(1'b1, addr_preset1 + 6'(i - 1), {16'h0, pf(3'(i))});
    set_fn(fn_binary_sel0);
    bus(1'b1, addr_ctrl, {30'h0, mode_binary});
    for (i = 7; i >= 0; i--)
    begin
      pins <= {2'h0, 3'(i)};
      wt(3'(i), pf(3'(i)), 1'b0);
    end
    bus(1'b0, addr_preset1, 32'h0);
    chk("preset read", 32'h0, rd);
    bus(1'b1, addr_settle, 32'h1);
    pins <= 5'h05;
    wt(3'h0, pf(3'h0), 1'b0);
    bus(1'b1, addr_settle, 32'h0);
    wt(3'h5, pf(3'h5), 1'b0);
    pins <= 5'h00;
    bus(1'b1, addr_ctrl, 32'h10);
    analog_frequency_input_i <= 16'h2345;
    wt(3'h0, 16'h2345, 1'b0);
    $display("binary test done");
  endtask
  task t_bit;
    int i;
    static logic [2:0] pat [7] = '{3'h0, 3'h3, 3'h6, 3'h7, 3'h4, 3'h5, 3'h2};
    static logic [2:0] ex [7] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h3, 3'h1, 3'h2};
    bus(1'b1, addr_ctrl, {30'h0, mode_bit});
    set_fn(fn_bit_sel1);
    for (i = 0; i < 7; i++)
    begin
      pins <= {2'h0, pat[i]};
      wt(ex[i], pf(ex[i]), 1'b0);
    end
    bus(1'b0, addr_status, 32'h0);
    chk("status", 32'h02, {27'h0, rd[4:0]});
    $display("bit test done");
  endtask
  task t_ramp;
    bus(1'b1, addr_ctrl, {28'h0, ramp_by_terminal, mode_binary});
    bus(1'b1, addr_term_fn0 + 6'h3, {26'h0, fn_ramp_switch});
    bus(1'b1, addr_term_fn0 + 6'h4, 32'h10);
    ramp <= 3'h4;
    pins <= 5'h10;
    wt(3'h0, pf(3'h0), 1'b0);
    pins <= 5'h08;
    wt(3'h0, pf(3'h0), 1'b1);
    pins <= 5'h00;
    wt(3'h0, pf(3'h0), 1'b0);
    bus(1'b1, addr_decel_thr, 32'hFFFF);
    bus(1'b0, addr_decel_thr, 32'h0);
    chk("threshold clip", {16'h0, thresh_max}, rd);
    bus(1'b1, addr_decel_thr, 32'h01F4);
    bus(1'b1, addr_accel_thr, 32'h03E8);
    bus(1'b1, addr_ctrl, {28'h0, ramp_by_threshold, mode_binary});
    output_frequency_i <= 16'h03E7;
    wt(3'h0, pf(3'h0), 1'b0);
    output_frequency_i <= 16'h03E8;
    wt(3'h0, pf(3'h0), 1'b1);
    ramp <= 3'h2;
    output_frequency_i <= 16'h0190;
    wt(3'h0, pf(3'h0), 1'b0);
    output_frequency_i <= 16'h0258;
    wt(3'h0, pf(3'h0), 1'b1);
    bus(1'b1, addr_ctrl, {28'h0, ramp_on_reverse, mode_binary});
    pins <= 5'h08;
    ramp <= 3'h0;
    wt(3'h0, pf(3'h0), 1'b0);
    ramp <= 3'h1;
    wt(3'h0, pf(3'h0), 1'b1);
    bus(1'b0, addr_status, 32'h0);
    chk("status ramp", 32'h10, {27'h0, rd[4:0]});
    bus(1'b1, addr_ctrl, {28'h0, 2'h3, mode_binary});
    wt(3'h0, pf(3'h0), 1'b0);
    $display("ramp test done");
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset;
    t_binary;
    t_bit;
    t_ramp;
    final_report;
  end
endmodule // multi_speed_accel_select_test
